// ===== pbd_core_end.sv
// Purpose: Core end of the dataflow port; turns bus transactions into backend strobes.
// Assumes: The bus engine outside gives start, stop and other-agent completions.
// Notes: Read words pass a small buffer so a stalled reader loses nothing.
`timescale 1ns/1ps
// Behaviour
// - Region code 0-5 bar, 6 rom, 7 idle.
// - Region valid at begin, 7 at end.
// - Cycle flags set at begin, cleared at end.
// - Every begin pulse gets a matching end.
// - Idle end pulses for other agents' completions.
// - Read word moves only when both strobes high.
// - Read ready timeout ends with disconnect.
// - Sample mode picks same or next edge capture.
// - Backend sets sample mode high for synchronous memories.
// - Write ready timeout causes disconnect.
// - One write strobe per byte, lane 0 low.
// - Address width parameter, low bits from bus.
// - Separate low and high data enables.
// - Byte lanes valid strobe qualifies read lanes.
// - Backend flags illegal I/O bytes via error.
// - Flush region fifo when flagged at begin.
// - Copy empty inputs into fifo status bits.
// - Present configuration status word continuously.
// - Export reset, also during hot-swap cycles.
// - Clock option drives bus clock out.
// - Fast clock pin low or released.
// - Wide acknowledge follows device select timing.
// - Recovery only for regions with option two.
module pbd_core_end #(
	parameter int DW = pbd_pkg::DATA_W,
	parameter int AW = pbd_pkg::ADDR_W,
	parameter int BUF_DEPTH = pbd_pkg::BUF_DEPTH,
	parameter int WAIT_LIMIT = pbd_pkg::WAIT_LIMIT,
	parameter logic [11:0] REGION_ENABLE_OPTION = pbd_pkg::REGION_ENABLE_DEF,
	parameter bit FIFO_STATUS_OPTION = 1'b1,
	parameter bit HOT_SWAP_OPTION = 1'b0,
	parameter bit DRIVE_BUS_CLOCK_OPTION = 1'b0,
	parameter bit FAST_CLOCK_SUPPORT = 1'b0
)(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic ce,
	pbd_if.core bus,
	input wire logic txn_start,
	input wire pbd_pkg::pbd_region_t txn_region,
	input wire logic txn_read,
	input wire logic txn_wide,
	input wire logic [AW-1:0] txn_addr,
	input wire logic [DW/8-1:0] txn_lanes,
	input wire logic txn_stop,
	input wire logic other_done,
	input wire logic wr_valid,
	input wire logic [DW-1:0] wr_data,
	output logic wr_ready,
	output logic rd_valid,
	output logic [DW-1:0] rd_data,
	input wire logic rd_ready,
	output logic disconnect_pulse,
	output logic abort_pulse,
	output logic [5:0] fifo_flush_pulse,
	output logic [5:0] fifo_status,
	input wire logic [15:0] cfg_status_value,
	input wire logic hs_cycle,
	output logic bus_clk_out,
	output logic fast_clock_pin_o,
	output logic fast_clock_pin_oe,
	input wire logic req64_in,
	input wire logic devsel_in,
	output logic ack64_out
);
	import pbd_pkg::*;
	localparam int BW = DW / 8;
	localparam int PW = $clog2(BUF_DEPTH);
	localparam int CW = $clog2(BUF_DEPTH + 1);
	localparam int TW = $clog2(WAIT_LIMIT + 1);
	pbd_state_t state;
	logic in_xfer;
	logic rd_hit;
	logic pend;
	logic push;
	logic pop;
	logic waiting;
	logic timeout;
	logic finish;
	logic [TW-1:0] wait_cnt;
	logic [DW-1:0] buf_mem [BUF_DEPTH];
	logic [PW-1:0] wr_ptr;
	logic [PW-1:0] rd_ptr;
	logic [CW-1:0] count;
	logic [BW-1:0] lanes;
	logic [5:0] recov;

	assign in_xfer = (state == PBD_XFER) && ce;
	// Space counts a pending next-edge capture so the buffer cannot overrun.
	assign bus.core_read_strobe = in_xfer && bus.read_cycle_flag
		&& ((count + CW'(pend)) < CW'(BUF_DEPTH));
	assign rd_hit = bus.core_read_strobe && bus.backend_read_ready;
	assign push = (rd_hit && !bus.read_sample_mode) || pend;
	assign pop = rd_valid && rd_ready;
	assign rd_valid = (count != '0);
	assign rd_data = buf_mem[rd_ptr];
	assign wr_ready = in_xfer && bus.write_cycle_flag && bus.backend_write_ready;
	assign waiting = (bus.core_read_strobe && !bus.backend_read_ready)
		|| (in_xfer && bus.write_cycle_flag && wr_valid && !bus.backend_write_ready);
	assign timeout = waiting && (wait_cnt == TW'(WAIT_LIMIT - 1));
	assign finish = in_xfer && (txn_stop || timeout || bus.error);

	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			state <= PBD_IDLE;
			bus.transfer_begin_pulse <= 1'b0;
			bus.transfer_end_pulse <= 1'b0;
		end
		else if (ce)
		begin
			bus.transfer_begin_pulse <= 1'b0;
			bus.transfer_end_pulse <= 1'b0;
			case (state)
				PBD_IDLE:
				begin
					if (txn_start)
					begin
						state <= PBD_XFER;
						bus.transfer_begin_pulse <= 1'b1;
					end
					else if (other_done)
						bus.transfer_end_pulse <= 1'b1;
				end
				PBD_XFER:
				begin
					if (finish)
					begin
						state <= PBD_END;
						bus.transfer_end_pulse <= 1'b1;
					end
				end
				PBD_END:
					state <= PBD_IDLE;
				default:
					state <= PBD_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			bus.region_select <= REGION_NONE;
			bus.read_cycle_flag <= 1'b0;
			bus.write_cycle_flag <= 1'b0;
			bus.wide_transfer_flag <= 1'b0;
			lanes <= '0;
		end
		else if (ce)
		begin
			if (state == PBD_IDLE && txn_start)
			begin
				bus.region_select <= txn_region;
				bus.read_cycle_flag <= txn_read;
				bus.write_cycle_flag <= !txn_read;
				bus.wide_transfer_flag <= txn_wide && (DW > 32);
				lanes <= txn_lanes;
			end
			else if (finish)
			begin
				bus.region_select <= REGION_NONE;
				bus.read_cycle_flag <= 1'b0;
				bus.write_cycle_flag <= 1'b0;
				bus.wide_transfer_flag <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
			bus.addr <= '0;
		else if (ce)
		begin
			if (state == PBD_IDLE && txn_start)
				bus.addr <= txn_addr;
			// Write strobes are registered, so a write steps the address only after
			// the backend has used it; stepping at acceptance would shift every word.
			else if (rd_hit || (|bus.byte_write_strobes))
				bus.addr <= {bus.addr[AW-1:2] + (AW-2)'(1), bus.addr[1:0]};
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
			wait_cnt <= '0;
		else if (ce)
			wait_cnt <= (waiting && !timeout) ? wait_cnt + TW'(1) : '0;
	end

	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			disconnect_pulse <= 1'b0;
			abort_pulse <= 1'b0;
		end
		else if (ce)
		begin
			disconnect_pulse <= in_xfer && timeout && !bus.error;
			abort_pulse <= in_xfer && bus.error;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
			pend <= 1'b0;
		else if (ce)
			pend <= rd_hit && bus.read_sample_mode;
	end

	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
			for (int i = 0; i < BUF_DEPTH; i++)
				buf_mem[i] <= '0;
		end
		else if (ce)
		begin
			if (push)
			begin
				buf_mem[wr_ptr] <= bus.data_in;
				wr_ptr <= wr_ptr + PW'(1);
			end
			if (pop)
				rd_ptr <= rd_ptr + PW'(1);
			count <= count + CW'(push) - CW'(pop);
		end
	end

	// Write data and strobes are registered so the backend sees clean edges.
	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			bus.data_out <= '0;
			bus.byte_write_strobes <= '0;
		end
		else if (ce)
		begin
			bus.byte_write_strobes <= (wr_ready && wr_valid) ? lanes : '0;
			if (wr_ready && wr_valid)
				bus.data_out <= wr_data;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			bus.data_out_enable <= 1'b0;
			bus.data_out_enable_high <= 1'b0;
			bus.byte_lanes_valid_n <= 1'b1;
			bus.read_byte_lanes_n <= '1;
		end
		else if (ce)
		begin
			bus.data_out_enable <= bus.write_cycle_flag && !finish;
			bus.data_out_enable_high <= bus.write_cycle_flag && bus.wide_transfer_flag
				&& !finish;
			bus.byte_lanes_valid_n <= !((state == PBD_XFER) && !finish);
			bus.read_byte_lanes_n <= ~lanes;
		end
	end

	genvar r;
	generate
		for (r = 0; r < REGIONS; r++)
		begin : g_region
			assign recov[r] = (REGION_ENABLE_OPTION[2*r +: 2] == RECOVERY_CODE);
			always_ff @(posedge clk_sys)
			begin
				if (!nrst)
				begin
					fifo_flush_pulse[r] <= 1'b0;
					fifo_status[r] <= FIFO_STATUS_RST[r];
				end
				else if (ce)
				begin
					fifo_flush_pulse[r] <= bus.transfer_begin_pulse && bus.flush[r]
						&& recov[r];
					// The empty input only feeds the status bit, never control.
					fifo_status[r] <= recov[r] && FIFO_STATUS_OPTION
						&& !bus.ext_fifo_empty_n[r];
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_sys)
	begin
		if (!nrst)
		begin
			bus.cfg_status <= CFG_STATUS_RST;
			bus.reset_export_n <= 1'b0;
		end
		else if (ce)
		begin
			bus.cfg_status <= cfg_status_value;
			bus.reset_export_n <= !(HOT_SWAP_OPTION && hs_cycle);
		end
	end

	// The clock passes straight through; a gated copy would skew the bus.
	assign bus_clk_out = DRIVE_BUS_CLOCK_OPTION ? clk_sys : 1'b0;
	assign fast_clock_pin_o = 1'b0;
	assign fast_clock_pin_oe = !FAST_CLOCK_SUPPORT;
	assign ack64_out = (DW > 32) && req64_in && devsel_in;
endmodule

// ===== pbd_pkg.sv
// Purpose: Shared constants and types for the backend dataflow port.
// Assumes: One clock, synchronous active-low reset.
// Notes: Counts are in clk_sys cycles.
package pbd_pkg;
	localparam int DATA_W = 32;
	localparam int ADDR_W = 16;
	localparam int REGIONS = 6;
	localparam int BUF_DEPTH = 2;
	localparam int MEM_DEPTH = 16;
	localparam int WAIT_LIMIT = 16;
	localparam logic [2:0] REGION_ROM = 3'h6;
	localparam logic [2:0] REGION_NONE = 3'h7;
	localparam logic [1:0] RECOVERY_CODE = 2'h2;
	localparam logic [11:0] REGION_ENABLE_DEF = 12'hAAA;
	localparam logic [15:0] CFG_STATUS_RST = 16'h0000;
	localparam logic [5:0] FIFO_STATUS_RST = 6'h00;
	typedef logic [2:0] pbd_region_t;
	typedef enum logic [1:0] {
		PBD_IDLE = 2'b00,
		PBD_XFER = 2'b01,
		PBD_END = 2'b11
	} pbd_state_t;
endpackage

// ===== pbd_if.sv
// Purpose: Dataflow link between the core end and the backend end.
// Assumes: All signals synchronous to clk_sys.
// Notes: The testbench joins data_out and data_in into one bus if it wants.
`timescale 1ns/1ps
interface pbd_if #(
	parameter int DW = 32,
	parameter int AW = 16
);
	localparam int BW = DW / 8;
	logic [2:0] region_select;
	logic read_cycle_flag;
	logic write_cycle_flag;
	logic wide_transfer_flag;
	logic transfer_begin_pulse;
	logic transfer_end_pulse;
	logic core_read_strobe;
	logic backend_read_ready;
	logic read_sample_mode;
	logic backend_write_ready;
	logic [BW-1:0] byte_write_strobes;
	logic [AW-1:0] addr;
	logic [DW-1:0] data_out;
	logic [DW-1:0] data_in;
	logic data_out_enable;
	logic data_out_enable_high;
	logic byte_lanes_valid_n;
	logic [BW-1:0] read_byte_lanes_n;
	logic error;
	logic [5:0] flush;
	logic [5:0] ext_fifo_empty_n;
	logic [15:0] cfg_status;
	logic reset_export_n;
	modport core (
		output region_select, read_cycle_flag, write_cycle_flag, wide_transfer_flag,
		output transfer_begin_pulse, transfer_end_pulse, core_read_strobe,
		output byte_write_strobes, addr, data_out, data_out_enable, data_out_enable_high,
		output byte_lanes_valid_n, read_byte_lanes_n, cfg_status, reset_export_n,
		input backend_read_ready, read_sample_mode, backend_write_ready, data_in,
		input error, flush, ext_fifo_empty_n
	);
	modport backend (
		input region_select, read_cycle_flag, write_cycle_flag, wide_transfer_flag,
		input transfer_begin_pulse, transfer_end_pulse, core_read_strobe,
		input byte_write_strobes, addr, data_out, data_out_enable, data_out_enable_high,
		input byte_lanes_valid_n, read_byte_lanes_n, cfg_status, reset_export_n,
		output backend_read_ready, read_sample_mode, backend_write_ready, data_in,
		output error, flush, ext_fifo_empty_n
	);
endinterface

// ===== pbd_backend_end.sv
// Purpose: Backend end: a small flip-flop memory behind the dataflow link.
// Assumes: Memory word index taken from addr above the two byte bits.
// Notes: stall holds both ready inputs of the core low.
`timescale 1ns/1ps
module pbd_backend_end #(
	parameter int DW = pbd_pkg::DATA_W,
	parameter int AW = pbd_pkg::ADDR_W,
	parameter int DEPTH = pbd_pkg::MEM_DEPTH,
	parameter bit SYNC_READ = 1'b0
)(
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic ce,
	pbd_if.backend bus,
	input wire logic stall,
	input wire logic io_check,
	input wire logic [5:0] flush_req,
	input wire logic [5:0] fifo_empty,
	input wire logic [$clog2(DEPTH)-1:0] peek_addr,
	output logic [DW-1:0] peek_data
);
	import pbd_pkg::*;
	localparam int BW = DW / 8;
	localparam int IW = $clog2(DEPTH);
	logic [DW-1:0] mem [DEPTH];
	logic [DW-1:0] rd_word;
	logic [DW-1:0] sync_word;
	logic [DW-1:0] lane_mask;
	logic [IW-1:0] idx;
	logic [3:0] low_lanes;
	logic [3:0] below_mask;
	logic illegal;
	logic err;
	logic rst_any;

	// The exported reset also clears this end, so hot-swap cycles reset it.
	assign rst_any = !nrst || !bus.reset_export_n;
	assign idx = bus.addr[IW+1:2];
	assign bus.read_sample_mode = SYNC_READ;
	assign bus.backend_read_ready = bus.read_cycle_flag && !stall;
	assign bus.backend_write_ready = bus.write_cycle_flag && !stall && !err;
	assign bus.flush = flush_req;
	assign bus.ext_fifo_empty_n = ~fifo_empty;
	assign bus.error = err;

	genvar b;
	generate
		for (b = 0; b < BW; b++)
		begin : g_lane
			// Lanes are honoured only once the core marks them valid.
			assign lane_mask[b*8 +: 8] = (bus.byte_lanes_valid_n || !bus.read_byte_lanes_n[b])
				? 8'hFF : 8'h00;
		end
	endgenerate

	assign rd_word = mem[idx] & lane_mask;
	assign bus.data_in = SYNC_READ ? sync_word : rd_word;

	// A lane enabled below the starting byte offset is an illegal I/O access.
	assign low_lanes = ~bus.read_byte_lanes_n[3:0];
	assign below_mask = 4'((5'h01 << bus.addr[1:0]) - 5'h01);
	assign illegal = io_check && !bus.byte_lanes_valid_n && |(low_lanes & below_mask);

	always_ff @(posedge clk_sys)
	begin
		if (rst_any)
			err <= 1'b0;
		else if (ce)
			err <= ((bus.read_cycle_flag || bus.write_cycle_flag) && illegal)
				|| (err && !bus.transfer_end_pulse);
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst_any)
			sync_word <= '0;
		else if (ce && bus.core_read_strobe && bus.backend_read_ready)
			sync_word <= rd_word;
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst_any)
		begin
			for (int i = 0; i < DEPTH; i++)
				mem[i] <= '0;
		end
		else if (ce)
		begin
			for (int k = 0; k < BW; k++)
				if (bus.byte_write_strobes[k])
					mem[idx][k*8 +: 8] <= bus.data_out[k*8 +: 8];
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst_any)
			peek_data <= '0;
		else if (ce)
			peek_data <= mem[peek_addr];
	end
endmodule

// ===== pbd_assertions.sv
// Purpose: Concurrent checks on the link between the core end and the backend end.
// Assumes: Core end built with a wait limit of 4 cycles.
// Notes: Watches only signals driven by the core end, plus the read ready that qualifies them.
`timescale 1ns/1ps
module pbd_assertions (
	input wire logic clk_sys,
	input wire logic nrst,
	input wire logic [2:0] region_select,
	input wire logic read_cycle_flag,
	input wire logic write_cycle_flag,
	input wire logic wide_transfer_flag,
	input wire logic transfer_begin_pulse,
	input wire logic transfer_end_pulse,
	input wire logic core_read_strobe,
	input wire logic backend_read_ready,
	input wire logic byte_lanes_valid_n,
	input wire logic reset_export_n
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);

	chk_end_clears_all: assert property (transfer_end_pulse |-> region_select == 3'h7
		&& !read_cycle_flag && !write_cycle_flag && !wide_transfer_flag)
		else $error("end pulse with region or flags still set");
	chk_begin_valid: assert property (transfer_begin_pulse |-> region_select != 3'h7
		&& (read_cycle_flag != write_cycle_flag))
		else $error("begin pulse without a region or a single cycle flag");
	chk_begin_width: assert property (transfer_begin_pulse |=> !transfer_begin_pulse)
		else $error("begin pulse wider than one cycle");
	chk_end_width: assert property (transfer_end_pulse |=> !transfer_end_pulse)
		else $error("end pulse wider than one cycle");
	chk_begin_end_pair: assert property (transfer_begin_pulse |-> ##[1:64] transfer_end_pulse)
		else $error("begin pulse not followed by an end pulse");
	chk_region_stable: assert property (region_select != 3'h7 && !transfer_begin_pulse
		|-> $stable(region_select))
		else $error("region changed inside a transaction");
	chk_strobe_in_read: assert property (core_read_strobe |-> read_cycle_flag)
		else $error("read strobe outside a read transaction");
	// The repeat count equals the wait limit given to the core end in the bench.
	chk_read_timeout: assert property ((core_read_strobe && !backend_read_ready)[*4]
		|-> ##[1:2] transfer_end_pulse)
		else $error("stalled read not ended after the wait limit");
	chk_lanes_in_txn: assert property (!byte_lanes_valid_n |-> region_select != 3'h7)
		else $error("byte lanes marked valid outside a transaction");
	chk_reset_export: assert property (disable iff (1'b0) !nrst |=> !reset_export_n)
		else $error("exported reset not asserted after reset");

	cov_read_begin: cover property (transfer_begin_pulse && read_cycle_flag);
	cov_write_begin: cover property (transfer_begin_pulse && write_cycle_flag);
	cov_read_stall: cover property ((core_read_strobe && !backend_read_ready)[*4]);
endmodule

// ===== pci_backend_dataflow_port_tb.sv
// Purpose: Self-checking bench joining the core end and the backend end.
// Assumes: Core end uses a wait limit of 4 so timeouts stay short.
// Notes: Inputs change at rising edges; outputs are sampled 1 ns later, once settled.
`timescale 1ns/1ps
module pci_backend_dataflow_port_tb;
	import pbd_pkg::*;
	localparam int BW = DATA_W / 8;
	localparam logic [DATA_W-1:0] W0 = 32'hC0DE1234;
	localparam logic [DATA_W-1:0] W1 = 32'h5A5AF00F;
	logic clk_sys = 1'b0, nrst = 1'b0, ce = 1'b1, hs_cycle = 1'b0, txn_wide = 1'b1;
	logic txn_start = 1'b0, txn_read = 1'b0, txn_stop = 1'b0, other_done = 1'b0;
	logic wr_valid = 1'b0, rd_ready = 1'b0, req64_in = 1'b0, devsel_in = 1'b0;
	logic stall = 1'b0, io_check = 1'b0, wr_ready, rd_valid, disconnect_pulse, abort_pulse;
	logic bus_clk_out, pin_o, pin_oe, ack64_out;
	pbd_region_t txn_region = 3'h0;
	logic [ADDR_W-1:0] txn_addr = 16'h0000;
	logic [BW-1:0] txn_lanes = 4'hF;
	logic [DATA_W-1:0] wr_data = 32'h00000000, rd_data, peek_data;
	logic [5:0] flush_req = 6'h00, fifo_empty = 6'h00, fifo_flush_pulse, fifo_status;
	logic [15:0] cfg_status_value = 16'h0000;
	logic [$clog2(MEM_DEPTH)-1:0] peek_addr = '0;
	int errors = 0, num_checks = 0;

	pbd_if #(.DW(DATA_W), .AW(ADDR_W)) link ();
	pbd_core_end #(.WAIT_LIMIT(4)) pbd_core_end_i (.clk_sys(clk_sys), .nrst(nrst), .ce(ce),
		.bus(link.core), .txn_start(txn_start), .txn_region(txn_region), .txn_read(txn_read),
		.txn_wide(txn_wide), .txn_addr(txn_addr), .txn_lanes(txn_lanes), .txn_stop(txn_stop),
		.other_done(other_done), .wr_valid(wr_valid), .wr_data(wr_data), .wr_ready(wr_ready),
		.rd_valid(rd_valid), .rd_data(rd_data), .rd_ready(rd_ready),
		.disconnect_pulse(disconnect_pulse), .abort_pulse(abort_pulse),
		.fifo_flush_pulse(fifo_flush_pulse), .fifo_status(fifo_status),
		.cfg_status_value(cfg_status_value), .hs_cycle(hs_cycle), .bus_clk_out(bus_clk_out),
		.fast_clock_pin_o(pin_o), .fast_clock_pin_oe(pin_oe), .req64_in(req64_in),
		.devsel_in(devsel_in), .ack64_out(ack64_out));
	pbd_backend_end pbd_backend_end_i (.clk_sys(clk_sys), .nrst(nrst), .ce(ce),
		.bus(link.backend), .stall(stall), .io_check(io_check), .flush_req(flush_req),
		.fifo_empty(fifo_empty), .peek_addr(peek_addr), .peek_data(peek_data));
	pbd_assertions pbd_assertions_i (.clk_sys(clk_sys), .nrst(nrst),
		.region_select(link.region_select), .read_cycle_flag(link.read_cycle_flag),
		.write_cycle_flag(link.write_cycle_flag), .wide_transfer_flag(link.wide_transfer_flag),
		.transfer_begin_pulse(link.transfer_begin_pulse),
		.transfer_end_pulse(link.transfer_end_pulse), .core_read_strobe(link.core_read_strobe),
		.backend_read_ready(link.backend_read_ready), .byte_lanes_valid_n(link.byte_lanes_valid_n),
		.reset_export_n(link.reset_export_n));

	initial forever #10 clk_sys = ~clk_sys;

	task automatic cmp(input string name, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] got);
		num_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic conclude;
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Drives one start request and judges the begin cycle.
	task automatic begin_txn(input pbd_region_t r, input logic rd, input logic [ADDR_W-1:0] a,
		input logic [BW-1:0] l);
		logic [BW-1:0] nl;
		nl = ~l;
		@(posedge clk_sys);
		txn_start <= 1'b1;
		txn_region <= r;
		txn_read <= rd;
		txn_addr <= a;
		txn_lanes <= l;
		@(posedge clk_sys);
		txn_start <= 1'b0;
		#1;
		cmp("begin", 1, link.transfer_begin_pulse);
		cmp("region", r, link.region_select);
		cmp("read flag", rd, link.read_cycle_flag);
		cmp("write flag", !rd, link.write_cycle_flag);
		cmp("wide flag", 0, link.wide_transfer_flag);
		cmp("addr low", a[1:0], link.addr[1:0]);
		// The lanes and their valid strobe are registered one cycle after the begin pulse.
		@(posedge clk_sys);
		#1;
		cmp("lanes", nl, link.read_byte_lanes_n);
		cmp("lanes valid", 0, link.byte_lanes_valid_n);
	endtask

	task automatic end_txn;
		@(posedge clk_sys);
		txn_stop <= 1'b1;
		@(posedge clk_sys);
		txn_stop <= 1'b0;
		#1;
		cmp("end", 1, link.transfer_end_pulse);
		cmp("end region", 3'h7, link.region_select);
		cmp("end read flag", 0, link.read_cycle_flag);
		cmp("end lanes valid", 1, link.byte_lanes_valid_n);
	endtask

	task automatic put(input logic [DATA_W-1:0] w);
		int k;
		@(posedge clk_sys);
		wr_valid <= 1'b1;
		wr_data <= w;
		#1;
		for (k = 0; k < 20 && wr_ready !== 1'b1; k++)
		begin
			@(posedge clk_sys);
			#1;
		end
		@(posedge clk_sys);
		wr_valid <= 1'b0;
		#1;
		cmp("write strobes", 4'hF, link.byte_write_strobes);
		cmp("data out", w, link.data_out);
		cmp("data enable", 1, link.data_out_enable);
		cmp("data enable high", 0, link.data_out_enable_high);
	endtask

	task automatic t_write;
		begin_txn(3'h0, 1'b0, 16'h0000, 4'hF);
		put(W0);
		put(W1);
		end_txn();
		@(posedge clk_sys);
		peek_addr <= 1;
		@(posedge clk_sys);
		#1;
		cmp("stored word", W1, peek_data);
	endtask

	// The reader holds rd_ready low first so the two-entry buffer fills and the strobe drops.
	task automatic t_read;
		int k;
		int got;
		got = 0;
		begin_txn(3'h1, 1'b1, 16'h0000, 4'hF);
		repeat (5) @(posedge clk_sys);
		#1;
		cmp("strobe when full", 0, link.core_read_strobe);
		@(posedge clk_sys);
		rd_ready <= 1'b1;
		for (k = 0; k < 20 && got < 2; k++)
		begin
			#1;
			if (rd_valid === 1'b1)
			begin
				cmp("read word", got == 0 ? W0 : W1, rd_data);
				got++;
			end
			@(posedge clk_sys);
		end
		cmp("read count", 2, got);
		end_txn();
	endtask

	task automatic t_timeout;
		int k;
		logic d;
		for (int rd = 0; rd < 2; rd++)
		begin
			d = 1'b0;
			@(posedge clk_sys);
			stall <= 1'b1;
			flush_req <= 6'h04;
			begin_txn(3'h2, rd[0], 16'h0000, 4'hF);
			cmp("flush", 6'h04, fifo_flush_pulse);
			@(posedge clk_sys);
			wr_valid <= !rd[0];
			#1;
			for (k = 0; k < 30 && link.transfer_end_pulse !== 1'b1; k++)
			begin
				@(posedge clk_sys);
				#1;
				d = d | (disconnect_pulse === 1'b1);
			end
			cmp("disconnect", 1, d);
			cmp("timeout end", 1, link.transfer_end_pulse);
			@(posedge clk_sys);
			stall <= 1'b0;
			wr_valid <= 1'b0;
			flush_req <= 6'h00;
		end
	endtask

	task automatic t_abort;
		int k;
		@(posedge clk_sys);
		io_check <= 1'b1;
		begin_txn(3'h4, 1'b0, 16'h0002, 4'h1);
		for (k = 0; k < 20 && abort_pulse !== 1'b1; k++)
		begin
			@(posedge clk_sys);
			#1;
		end
		cmp("abort", 1, abort_pulse);
		cmp("abort end", 1, link.transfer_end_pulse);
		@(posedge clk_sys);
		io_check <= 1'b0;
	endtask

	task automatic t_regions_and_stray;
		for (int r = 0; r < 7; r++)
		begin
			begin_txn(r[2:0], 1'b0, 16'h0000, 4'hF);
			end_txn();
		end
		@(posedge clk_sys);
		other_done <= 1'b1;
		@(posedge clk_sys);
		other_done <= 1'b0;
		#1;
		cmp("stray end", 1, link.transfer_end_pulse);
		cmp("stray begin", 0, link.transfer_begin_pulse);
	endtask

	task automatic t_static;
		@(posedge clk_sys);
		cfg_status_value <= 16'hA5C3;
		fifo_empty <= 6'h15;
		req64_in <= 1'b1;
		devsel_in <= 1'b1;
		repeat (3) @(posedge clk_sys);
		#1;
		cmp("cfg status", 16'hA5C3, link.cfg_status);
		cmp("fifo status", 6'h15, fifo_status);
		cmp("wide ack", 0, ack64_out);
		cmp("fast pin", 0, pin_o);
		cmp("fast pin oe", 1, pin_oe);
		cmp("reset out", 1, link.reset_export_n);
		cmp("bus clock", 0, bus_clk_out);
	endtask

	initial
	begin
		repeat (20000) @(posedge clk_sys);
		errors++;
		conclude();
	end

	initial
	begin
		repeat (16) @(posedge clk_sys);
		nrst <= 1'b1;
		repeat (3) @(posedge clk_sys);
		t_static();
		t_write();
		t_read();
		t_timeout();
		t_abort();
		t_regions_and_stray();
		conclude();
	end
endmodule
